// File: dv/glc_bank_tb.sv
// Self-checking bench for the global configuration bank
`timescale 1ns/1ns
module glc_bank_tb;
  import glc_pkg::*;
  localparam int MS = 10;
  logic       clock, reset, fade_request, bus_timeout, timeout_enabled;
  logic       int_n, part_enable, port_reset, port_write_ok, sink_10ma, fade_busy;
  glc_req_s   req;
  logic [7:0] rdata, q;
  logic [5:0] debounce_ms;
  logic [8:0] duty;
  int         num_errors = 0;
  int         n_checks = 0;
  int         n;

  glc_host_model host (.clock(clock), .rdata(rdata), .req(req), .bus_timeout(bus_timeout),
    .timeout_enabled(timeout_enabled));
  glc_bank #(.MS_CYCLES(MS)) DUT (.clock(clock), .reset(reset), .req(req), .bus_timeout(bus_timeout),
    .timeout_enabled(timeout_enabled), .fade_request(fade_request), .rdata(rdata), .int_n(int_n),
    .part_enable(part_enable), .port_reset(port_reset), .port_write_ok(port_write_ok),
    .debounce_ms(debounce_ms), .sink_10ma(sink_10ma), .duty(duty), .fade_busy(fade_busy));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input string s, input logic [8:0] e, input logic [8:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Outputs settle one cycle after the write edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
    repeat (2) @(negedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00, q);
    chk("rdata", {1'b0, e}, q);
  endtask
  // Bounded wait for the ramp to reach its end value, then judge its length
  task automatic fade(input logic on, input logic [8:0] target);
    @(negedge clock);
    fade_request = on;
    for (n = 0; n < 4000 && duty !== target; n++) @(negedge clock);
    if (n >= 4000) begin
      num_errors++;
      wrap_up();
    end
    chk("fade_time", 9'h001, 9'((n >= 240 * MS) && (n <= 272 * MS)));
    chk("fade_end", target, duty);
    chk("fade_busy", 9'h001, {8'h00, fade_busy});
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    fade_request = 1'b1;
    repeat (20) @(negedge clock);
    reset = 1'b0;
    rd(GLC_ADDR_GLOBAL_CFG, 8'h00);
    rd(GLC_ADDR_SINK_CUR, 8'hC0);
    rd(GLC_ADDR_TIMEOUT_FLG, 8'h00);
    chk("debounce_ms", 9'd9, {3'b0, debounce_ms});
    // Shut down: writes are dropped and outputs idle
    wr(GLC_ADDR_DEBOUNCE, 8'h1F);
    rd(GLC_ADDR_DEBOUNCE, 8'h00);
    chk("port_write_ok", 9'h000, {8'h00, port_write_ok});
    $display("test reset_and_shutdown done");
    wr(GLC_ADDR_GLOBAL_CFG, 8'h10);
    chk("part_enable", 9'h001, {8'h00, part_enable});
    chk("port_write_ok", 9'h001, {8'h00, port_write_ok});
    wr(GLC_ADDR_DEBOUNCE, 8'hFF);
    rd(GLC_ADDR_DEBOUNCE, 8'h1F);
    chk("debounce_ms", 9'd40, {3'b0, debounce_ms});
    wr(GLC_ADDR_SINK_CUR, 8'h01);
    rd(GLC_ADDR_SINK_CUR, 8'hC1);
    chk("sink_10ma", 9'h001, {8'h00, sink_10ma});
    wr(GLC_ADDR_COMMON_PWM, 8'h80);
    chk("duty", 9'd128, duty);
    wr(GLC_ADDR_COMMON_PWM, 8'hFF);
    chk("duty", 9'd256, duty);
    $display("test enable_fields done");
    wr(GLC_ADDR_GLOBAL_CFG, 8'h11);
    fade(1'b0, 9'd0);
    fade(1'b1, 9'd256);
    wr(GLC_ADDR_GLOBAL_CFG, 8'h16);
    fade_request = 1'b0;
    repeat (3) @(negedge clock);
    chk("duty_nofade", 9'd0, duty);
    chk("fade_busy", 9'h000, {8'h00, fade_busy});
    $display("test fade done");
    // Timeouts: ignored while detection off, flag otherwise, interrupt only with irq enabled
    wr(GLC_ADDR_GLOBAL_CFG, 8'h30);
    host.timeout(1'b0);
    rd(GLC_ADDR_TIMEOUT_FLG, 8'h00);
    chk("int_n", 9'h001, {8'h00, int_n});
    host.timeout(1'b1);
    repeat (2) @(negedge clock);
    chk("int_n", 9'h000, {8'h00, int_n});
    rd(GLC_ADDR_TIMEOUT_FLG, 8'h01);
    repeat (2) @(negedge clock);
    chk("int_n", 9'h001, {8'h00, int_n});
    rd(GLC_ADDR_TIMEOUT_FLG, 8'h00);
    wr(GLC_ADDR_GLOBAL_CFG, 8'h10);
    host.timeout(1'b1);
    repeat (2) @(negedge clock);
    chk("int_n", 9'h001, {8'h00, int_n});
    wr(GLC_ADDR_TIMEOUT_FLG, 8'hFF);
    rd(GLC_ADDR_TIMEOUT_FLG, 8'h01);
    $display("test timeout done");
    // Disable keeps contents; soft reset then restores them
    fade_request = 1'b1;
    wr(GLC_ADDR_GLOBAL_CFG, 8'h00);
    chk("duty_off", 9'd0, duty);
    wr(GLC_ADDR_COMMON_PWM, 8'h12);
    rd(GLC_ADDR_COMMON_PWM, 8'hFF);
    host.access(1'b1, GLC_ADDR_GLOBAL_CFG, 8'h18, q);
    chk("port_reset", 9'h001, {8'h00, port_reset});
    @(negedge clock);
    chk("port_reset", 9'h000, {8'h00, port_reset});
    rd(GLC_ADDR_GLOBAL_CFG, 8'h10);
    rd(GLC_ADDR_COMMON_PWM, 8'h00);
    $display("test soft_reset done");
    wrap_up();
  end
endmodule

// File: dv/glc_host_model.sv
// Host-side model: register accesses and bus timeout events
`timescale 1ns/1ns
module glc_host_model
  import glc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic [7:0]  rdata,
  output glc_pkg::glc_req_s req,
  output logic             bus_timeout,
  output logic             timeout_enabled
);
  initial begin
    req = '0;
    bus_timeout = 1'b0;
    timeout_enabled = 1'b0;
  end
  // One cycle per access; the released bus shows inverted values, not stale ones
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clock);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = rdata;
  endtask
  // Detection is set up a cycle ahead of the timeout pulse
  task automatic timeout(input logic en);
    @(negedge clock);
    timeout_enabled = en;
    @(negedge clock);
    bus_timeout = 1'b1;
    @(negedge clock);
    bus_timeout = 1'b0;
  endtask
endmodule

// File: src/glc_bank.sv
// Global configuration and status register bank of the expander
// Operation
// (RULE1) With timeout irq enabled, timeout asserts low interrupt; flag register read releases it.
// (RULE2) Enable clear shuts PWM, sinks, inputs; port registers held and write-protected.
// (RULE3) Enable set runs PWM, sinks and all ports normally.
// (RULE4) Soft reset bit restores port registers; bit clears itself after the write.
// (RULE5) Fade code zero disables fading; others ramp in sixteen steps. The code treats codes 6 and 7 as no fade as well.
// (RULE6) Fade codes 1..5 give 256 to 4096 ms; 6 and 7 undefined.
// (RULE7) Debounce time is nine milliseconds plus field value.
// (RULE8) Current bit zero selects 20mA, one selects 10mA.
// (RULE9) PWM duty is value over 256; all ones means full duty.
// (RULE10) Timeout flag set by timeout, cleared by reading its register.
// (RULE11) Flag only sets while bus timeout detection is enabled.
// (RULE12) Flag register read only, upper seven bits zero.
// (RULE13) Each fade step lasts one sixteenth of fade duration.
`timescale 1ns/1ns
module glc_bank
  import glc_pkg::*;
#(
  parameter int MS_CYCLES = GLC_MS_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire glc_pkg::glc_req_s req,
  input  wire logic       bus_timeout,
  input  wire logic       timeout_enabled,
  input  wire logic       fade_request,
  output logic [7:0]      rdata,
  output logic            int_n,
  output logic            part_enable,
  output logic            port_reset,
  output logic            port_write_ok,
  output logic [5:0]      debounce_ms,
  output logic            sink_10ma,
  output logic [8:0]      duty,
  output logic            fade_busy
);
  logic [7:0] cfg;
  logic [7:0] deb;
  logic [7:0] cur;
  logic [7:0] pwm;
  logic       flag;
  logic       to_irq;
  logic       ms_tick;
  logic [12:0] ms_count;
  logic [4:0]  fade_level;
  logic        fade_up;
  logic        fade_req_d;

  // Level 0 is dark, FADE_TOP is the full common ratio: sixteen steps apart
  localparam logic [4:0] FADE_TOP = 5'(GLC_FADE_STEPS_M1) + 5'h1;

  // Millisecond base for fade timing
  glc_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
    .clock (clock),
    .reset (reset),
    .run   (cfg[GLC_BIT_ENABLE]),
    .tick  (ms_tick)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // Step length in ms: duration/16, doubling per code
  function automatic logic [12:0] step_ms(input logic [2:0] code);
    return 13'(GLC_FADE_STEP_MS << (code - 3'h1));
  endfunction

  // Duty from full level and fade level; wide product so 256 x 16 cannot wrap
  function automatic logic [8:0] scale_duty(input logic [8:0] full, input logic [4:0] level);
    logic [13:0] prod;
    prod = 14'(full) * 14'(level);
    return prod[12:4];
  endfunction

  // Configuration register; soft reset bit never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      cfg <= GLC_RESET_ZERO;
    end else if (req.wr && hit(req.addr, GLC_ADDR_GLOBAL_CFG)) begin
      cfg <= req.wdata & GLC_CFG_WMASK; // [RULE4]
    end
  end

  // Momentary port reset pulse, one cycle after the write
  always_ff @(posedge clock) begin
    if (reset) begin
      port_reset <= 1'b0;
    end else begin
      port_reset <= req.wr && hit(req.addr, GLC_ADDR_GLOBAL_CFG) && req.wdata[GLC_BIT_SOFT_RST]; // [RULE4]
    end
  end

  // Port-range registers accept writes only while enabled
  always_ff @(posedge clock) begin
    if (reset) begin
      deb <= GLC_RESET_ZERO;
      cur <= GLC_CUR_FIXED;
      pwm <= GLC_RESET_ZERO;
    end else if (port_reset) begin
      deb <= GLC_RESET_ZERO; // [RULE4]
      cur <= GLC_CUR_FIXED;
      pwm <= GLC_RESET_ZERO;
    end else if (req.wr && cfg[GLC_BIT_ENABLE]) begin // [RULE2]
      if (hit(req.addr, GLC_ADDR_DEBOUNCE)) begin
        deb <= req.wdata & GLC_DEB_WMASK;
      end
      if (hit(req.addr, GLC_ADDR_SINK_CUR)) begin
        cur <= GLC_CUR_FIXED | (req.wdata & GLC_CUR_WMASK);
      end
      if (hit(req.addr, GLC_ADDR_COMMON_PWM)) begin
        pwm <= req.wdata;
      end
    end
  end

  // Timeout flag: set wins over read clear
  always_ff @(posedge clock) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (bus_timeout && timeout_enabled) begin
      flag <= 1'b1; // [RULE11]
    end else if (req.rd && hit(req.addr, GLC_ADDR_TIMEOUT_FLG)) begin
      flag <= 1'b0; // [RULE10]
    end
  end

  // Interrupt latch, released by a flag register read
  always_ff @(posedge clock) begin
    if (reset) begin
      to_irq <= 1'b0;
    end else if (bus_timeout && timeout_enabled && cfg[GLC_BIT_TO_IRQ_EN]) begin
      to_irq <= 1'b1; // [RULE1]
    end else if (req.rd && hit(req.addr, GLC_ADDR_TIMEOUT_FLG)) begin
      to_irq <= 1'b0; // [RULE1]
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      int_n <= 1'b1;
    end else begin
      int_n <= !to_irq; // [RULE1]
    end
  end

  // Read data; unmapped addresses return zero
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= GLC_RESET_ZERO;
    end else if (req.rd) begin
      unique case (req.addr)
        GLC_ADDR_GLOBAL_CFG:  rdata <= cfg;
        GLC_ADDR_DEBOUNCE:    rdata <= deb;
        GLC_ADDR_SINK_CUR:    rdata <= cur;
        GLC_ADDR_COMMON_PWM:  rdata <= pwm;
        GLC_ADDR_TIMEOUT_FLG: rdata <= {7'h00, flag}; // [RULE12]
        default:              rdata <= GLC_RESET_ZERO;
      endcase
    end
  end

  // Static controls to the analog and input blocks
  always_ff @(posedge clock) begin
    if (reset) begin
      part_enable   <= 1'b0;
      port_write_ok <= 1'b0;
      debounce_ms   <= 6'(GLC_DEBOUNCE_BASE);
      sink_10ma     <= 1'b0;
    end else begin
      part_enable   <= cfg[GLC_BIT_ENABLE]; // [RULE3]
      port_write_ok <= cfg[GLC_BIT_ENABLE]; // [RULE2]
      debounce_ms   <= 6'(GLC_DEBOUNCE_BASE) + deb[5:0]; // [RULE7]
      sink_10ma     <= cur[0]; // [RULE8]
    end
  end

  // Fade sequencer: 16 even steps between zero and common ratio
  always_ff @(posedge clock) begin
    if (reset) begin
      fade_req_d <= 1'b0;
      fade_up    <= 1'b0;
      fade_level <= 5'h0;
      ms_count   <= 13'h0;
      fade_busy  <= 1'b0;
    end else begin
      fade_req_d <= fade_request;
      if (cfg[2:0] == GLC_FADE_OFF || cfg[2:0] > GLC_FADE_MAX || !cfg[GLC_BIT_ENABLE]) begin
        fade_busy  <= 1'b0; // [RULE5]
        fade_up    <= fade_request;
        fade_level <= fade_request ? FADE_TOP : 5'h0;
      end else if (fade_request != fade_req_d) begin
        fade_busy <= 1'b1;
        fade_up   <= fade_request;
        ms_count  <= 13'h0;
      end else if (fade_busy && ms_tick) begin
        if (ms_count == step_ms(cfg[2:0]) - 13'h1) begin // [RULE13]
          ms_count <= 13'h0;
          if (fade_up && fade_level != FADE_TOP) begin
            fade_level <= fade_level + 5'h1; // [RULE6]
          end else if (!fade_up && fade_level != 5'h0) begin
            fade_level <= fade_level - 5'h1;
          end else begin
            fade_busy <= 1'b0;
          end
        end else begin
          ms_count <= ms_count + 13'h1;
        end
      end
    end
  end

  // Duty out of 256; all-ones means full duty
  always_ff @(posedge clock) begin
    if (reset) begin
      duty <= 9'h000;
    end else if (!cfg[GLC_BIT_ENABLE]) begin
      duty <= 9'h000; // [RULE2]
    end else begin
      duty <= scale_duty((pwm == GLC_PWM_FULL) ? 9'h100 : {1'b0, pwm}, fade_level); // [RULE9]
    end
  end

  a_flag_clear_read: assert property (@(posedge clock) disable iff (reset)
    (req.rd && hit(req.addr, GLC_ADDR_TIMEOUT_FLG) && !(bus_timeout && timeout_enabled)) |=> !flag) // [RULE10]
    else $error("flag not cleared by read");
  a_flag_needs_enable: assert property (@(posedge clock) disable iff (reset)
    $rose(flag) |-> $past(timeout_enabled)) // [RULE11]
    else $error("flag set without enable");
  a_irq_asserts: assert property (@(posedge clock) disable iff (reset)
    (bus_timeout && timeout_enabled && cfg[GLC_BIT_TO_IRQ_EN]) |=> ##1 !int_n) // [RULE1]
    else $error("interrupt not asserted");
  a_soft_reset_self: assert property (@(posedge clock) disable iff (reset)
    port_reset |-> !cfg[GLC_BIT_SOFT_RST] ##1 (pwm == GLC_RESET_ZERO)) // [RULE4]
    else $error("soft reset misbehaved");
  a_write_blocked: assert property (@(posedge clock) disable iff (reset)
    (!cfg[GLC_BIT_ENABLE] && !port_reset) |=> $stable(pwm)) // [RULE2]
    else $error("write while disabled");
  a_flag_upper_zero: assert property (@(posedge clock) disable iff (reset)
    $past(req.rd && hit(req.addr, GLC_ADDR_TIMEOUT_FLG)) |-> rdata[7:1] == 7'h00) // [RULE12]
    else $error("flag upper bits nonzero");
  a_debounce_sum: assert property (@(posedge clock) disable iff (reset)
    ##2 debounce_ms == 6'(GLC_DEBOUNCE_BASE) + $past(deb[5:0])) // [RULE7]
    else $error("debounce time wrong");
  a_full_duty: assert property (@(posedge clock) disable iff (reset)
    (pwm == GLC_PWM_FULL && fade_level == FADE_TOP && cfg[GLC_BIT_ENABLE]) |=> duty == 9'h100) // [RULE9]
    else $error("full duty missing");
  a_current_sel: assert property (@(posedge clock) disable iff (reset)
    ##1 sink_10ma == $past(cur[0])) // [RULE8]
    else $error("sink select wrong");
  c_timeout_irq: cover property (@(posedge clock) disable iff (reset) $fell(int_n));
  c_soft_reset: cover property (@(posedge clock) disable iff (reset) port_reset);
  c_fade_done: cover property (@(posedge clock) disable iff (reset) $fell(fade_busy));
endmodule

// File: src/glc_ms_tick.sv
// One-millisecond enable pulse divider
`timescale 1ns/1ns
module glc_ms_tick
  import glc_pkg::*;
#(
  parameter int MS_CYCLES = glc_pkg::GLC_MS_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic run,
  output logic      tick
);
  logic [17:0] count;
  // Divider stops while the part is shut down to save power
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == 18'(MS_CYCLES - 1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + 18'h1;
      tick  <= 1'b0;
    end
  end
endmodule

// File: src/glc_pkg.sv
// Package for the global configuration bank: offsets, fields, resets, timing
package glc_pkg;
  localparam logic [7:0] GLC_ADDR_GLOBAL_CFG  = 8'h40;
  localparam logic [7:0] GLC_ADDR_DEBOUNCE    = 8'h42;
  localparam logic [7:0] GLC_ADDR_SINK_CUR    = 8'h43;
  localparam logic [7:0] GLC_ADDR_COMMON_PWM  = 8'h45;
  localparam logic [7:0] GLC_ADDR_TIMEOUT_FLG = 8'h48;
  localparam logic [7:0] GLC_PORT_FIRST       = 8'h31;
  localparam logic [7:0] GLC_PORT_LAST        = 8'h5B;
  localparam int GLC_BIT_TO_IRQ_EN = 5;
  localparam int GLC_BIT_ENABLE    = 4;
  localparam int GLC_BIT_SOFT_RST  = 3;
  localparam logic [7:0] GLC_CFG_WMASK      = 8'h37;
  localparam logic [7:0] GLC_DEB_WMASK      = 8'h1F;
  localparam logic [7:0] GLC_CUR_WMASK      = 8'h01;
  localparam logic [7:0] GLC_CUR_FIXED      = 8'hC0;
  localparam logic [7:0] GLC_RESET_ZERO     = 8'h00;
  localparam logic [2:0] GLC_FADE_OFF       = 3'h0;
  localparam logic [2:0] GLC_FADE_MAX       = 3'h5;
  localparam logic [7:0] GLC_PWM_FULL       = 8'hFF;
  localparam logic [3:0] GLC_FADE_STEPS_M1  = 4'hF;
  localparam int GLC_CLOCK_MHZ     = 250;
  localparam int GLC_MS_CYCLES     = GLC_CLOCK_MHZ * 1000;
  localparam int GLC_DEBOUNCE_BASE = 9;
  localparam int GLC_FADE_BASE_MS  = 256;
  localparam int GLC_FADE_STEP_MS  = GLC_FADE_BASE_MS / 16;
  // Register read/write request from the serial protocol engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } glc_req_s;
endpackage
